// ### shared/task_file_pkg.sv
// Constants for the disk task-file host port
// Function
// - Unit bit picks slave or master; head bits.
// - Status byte: busy ready fault seek drq corrected_flag idx err.
// - Primary status read clears pending interrupt.
// - Command write sets busy until completion; reads drop it at each sector's data request.
// - Busy makes task-file reads return status.
// - Refuse commands when not ready; abort on loss.
// - Write fault aborts, refuses commands until cleared.
// - Seek done set after last seek finishes.
// - Data request high while transfer is due.
// - Corrected set when an ECC-repaired sector's data request is raised.
// - Error bit set on unrecoverable error.
// - Alternate status mirrors status, keeps interrupt.
// - Control reset bit holds device in reset.
// - Master waits for slave diagnostics, else 81h.
// - Interrupt disable tristates line, keeps pending.
// - Digital input shows change, gate, heads, selects.
// - Decode the documented command opcode set.
// - Recalibrate seeks zero; failure sets track-zero error.
// - Count zero means 256; long mode one sector.
// - Bit1 long, bit0 no-retry; correct only normal.
// - Interrupt as each sector's data becomes available.
// - Primary select plus three lines; aux select.
package task_file_pkg;
   // ----------------------------------------
   // Task-file addresses
   // ----------------------------------------
   localparam logic [2:0] ADDR_ERROR   = 3'h1;
   localparam logic [2:0] ADDR_COUNT   = 3'h2;
   localparam logic [2:0] ADDR_HEAD    = 3'h6;
   localparam logic [2:0] ADDR_STATUS  = 3'h7;
   localparam logic [2:0] ADDR_AUX_CTL = 3'h6;
   localparam logic [2:0] ADDR_AUX_DIN = 3'h7;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ST_BUSY  = 7;
   localparam int ST_READY = 6;
   localparam int ST_WF    = 5;
   localparam int ST_SEEK  = 4;
   localparam int ST_DRQ   = 3;
   localparam int ST_CORRECTED_FLAG  = 2;
   localparam int ST_IDX   = 1;
   localparam int ST_ERR   = 0;
   localparam int HD_UNIT  = 4;
   localparam int CTL_RST  = 2;
   localparam int CTL_IDS  = 1;
   localparam int CMD_LONG = 1;
   localparam int CMD_NORETRY = 0;
   // ----------------------------------------
   // Reset values and error codes
   // ----------------------------------------
   localparam logic [7:0] HEAD_RESET   = 8'ha0;
   localparam logic [7:0] ERR_NONE     = 8'h01;
   localparam logic [7:0] ERR_SLAVE    = 8'h81;
   localparam logic [7:0] ERR_ABORT    = 8'h04;
   localparam logic [7:0] ERR_TRACK0   = 8'h02;
   localparam logic [7:0] ERR_UNCORR   = 8'h40;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ       = 40;
   localparam int RST_MIN_NS    = 5000;
   localparam int RST_MIN_CYC   = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int DIAG_WAIT_S   = 30;
   localparam longint DIAG_WAIT_CYC = longint'(DIAG_WAIT_S) * CLK_MHZ * 1000000;
   localparam int SECTOR_WORDS  = 256;
   localparam int LONG_BYTES    = 4;
   // ----------------------------------------
   // Command classes
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_RECAL, CMD_READ, CMD_WRITE, CMD_VERIFY, CMD_FORMAT, CMD_SEEK, CMD_DIAG,
      CMD_SETPAR, CMD_DMA, CMD_MULTI, CMD_POWER, CMD_BUFFER, CMD_IDENT, CMD_FEAT,
      CMD_XLATE, CMD_BAD
   } cmd_class_t;
endpackage : task_file_pkg

// ### rtl/disk_task_file_host_port.sv
// Task-file register front end with recalibrate and read sector engines
`timescale 1ns/10ps
module disk_task_file_host_port #(
   parameter longint DIAG_WAIT = task_file_pkg::DIAG_WAIT_CYC,
   parameter bit     IS_SLAVE  = 1'b0
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       primary_chip_select_n,
   input  wire logic       aux_chip_select_n,
   input  wire logic [2:0] host_addr_lines,
   input  wire logic       host_rd_n,
   input  wire logic       host_wr_n,
   input  wire logic [7:0] host_wdata,
   output logic      [7:0] host_rdata,
   output logic            host_rdata_oe,
   output logic            host_interrupt_line,
   output logic            host_interrupt_oe,
   input  wire logic       diag_passed_line_in,
   output logic            diag_passed_line_out,
   output logic            diag_passed_line_oe,
   input  wire logic       drive_ready_in,
   input  wire logic       write_fault_in,
   input  wire logic       index_in,
   input  wire logic       seek_done_in,
   input  wire logic       track_zero_in,
   input  wire logic       media_change_in,
   input  wire logic       floppy_present,
   input  wire logic       sector_ready_in,
   input  wire logic       sector_corrected_in,
   input  wire logic       sector_uncorrectable_in,
   input  wire logic       data_word_taken,
   output logic            seek_req,
   output logic            seek_to_zero,
   output logic            ecc_correct_en,
   output logic            unit_slave_sel,
   output logic      [3:0] head_select_bits,
   output logic            write_gate_line_n,
   output logic      [1:0] drive_select_lines_n,
   output logic      [8:0] sectors_left
);
   import task_file_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [12:0] sync1_q, sync2_q;
   // Two flops for the strobe, select and drive status inputs; address, data and sector_corrected_in are used unsynchronised
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_q <= 13'h1f80;
         sync2_q <= 13'h1f80;
      end
      else if (clk_en)
      begin
         sync1_q <= {host_rd_n, host_wr_n, primary_chip_select_n, aux_chip_select_n, diag_passed_line_in,
                     drive_ready_in, write_fault_in, index_in, seek_done_in, track_zero_in,
                     media_change_in, sector_ready_in, sector_uncorrectable_in};
         sync2_q <= sync1_q;
      end
   end
   logic rd_n_s, wr_n_s, cs0_n_s, cs1_n_s, diag_s, rdy_s, wf_s, idx_s, seek_s, tk0_s, chg_s, srdy_s, unc_s;
   assign {rd_n_s, wr_n_s, cs0_n_s, cs1_n_s, diag_s, rdy_s, wf_s, idx_s, seek_s, tk0_s, chg_s, srdy_s,
           unc_s} = sync2_q;

   // Strobe edges for single access events
   logic rd_prev_q, wr_prev_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
      end
      else if (clk_en)
      begin
         rd_prev_q <= rd_n_s;
         wr_prev_q <= wr_n_s;
      end
   end
   logic rd_ev, wr_ev, sel_pri, sel_aux;
   assign rd_ev   = rd_prev_q & ~rd_n_s;
   assign wr_ev   = wr_prev_q & ~wr_n_s;
   assign sel_pri = ~cs0_n_s & cs1_n_s;
   assign sel_aux = cs0_n_s & ~cs1_n_s;

   // ----------------------------------------
   // Opcode decode
   // ----------------------------------------
   function automatic cmd_class_t decode_cmd(input logic [7:0] op);
      cmd_class_t c;
      c = CMD_BAD;
      case (op[7:4])
         4'h1: c = CMD_RECAL;
         4'h2: c = CMD_READ;
         4'h3: c = CMD_WRITE;
         4'h4: c = CMD_VERIFY;
         4'h7: c = CMD_SEEK;
         default: c = CMD_BAD;
      endcase
      case (op)
         8'h50: c = CMD_FORMAT;
         8'h90: c = CMD_DIAG;
         8'h91: c = CMD_SETPAR;
         8'hc8, 8'hc9, 8'hca, 8'hcb: c = CMD_DMA;
         8'hc4, 8'hc5, 8'hc6: c = CMD_MULTI;
         8'he0, 8'he1, 8'he2, 8'he3, 8'he5, 8'he6, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99: c = CMD_POWER;
         8'he4, 8'he8: c = CMD_BUFFER;
         8'hec: c = CMD_IDENT;
         8'hef: c = CMD_FEAT;
         8'hf5: c = CMD_XLATE;
         default: ;
      endcase
      return c;
   endfunction : decode_cmd

   // ----------------------------------------
   // Host registers
   // ----------------------------------------
   logic [7:0] head_q, count_q, ctl_q, cmd_q;
   logic       soft_rst;
   assign soft_rst = ctl_q[CTL_RST];
   // Control register lives outside the soft reset so it can release it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctl_q <= 8'h02;
      else if (clk_en && wr_ev && sel_aux && host_addr_lines == ADDR_AUX_CTL)
         ctl_q <= host_wdata & 8'h06;
   end

   typedef enum {S_IDLE, S_RESET, S_DIAG, S_RECAL, S_SECT_WAIT, S_SECT_XFER, S_DONE} state_t;
   state_t     state_q;
   logic       busy_q, drq_q, seek_done_q, corrected_flag_q, err_q, wf_seen_q, pend_q, long_q;
   logic [7:0] error_q;
   logic [8:0] left_q, words_q;
   logic [63:0] wait_q;
   cmd_class_t  cls;
   logic       cmd_wr, can_run;
   assign cls    = decode_cmd(host_wdata);
   assign cmd_wr = wr_ev && sel_pri && host_addr_lines == ADDR_STATUS && !busy_q;
   assign can_run = rdy_s & ~wf_s;

   // Parameter registers written while busy is clear, including during a sector transfer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         head_q  <= HEAD_RESET;
         count_q <= 8'h01;
      end
      else if (clk_en && wr_ev && sel_pri && !busy_q)
      begin
         if (host_addr_lines == ADDR_HEAD)
            head_q <= host_wdata;
         if (host_addr_lines == ADDR_COUNT)
            count_q <= host_wdata;
      end
   end

   // ----------------------------------------
   // Command engine
   // ----------------------------------------
   logic [7:0] status;
   assign status = {busy_q, rdy_s, wf_seen_q, seek_done_q, drq_q, corrected_flag_q, idx_s, err_q};
   logic rd_status;
   assign rd_status = rd_ev && sel_pri && host_addr_lines == ADDR_STATUS;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= S_RESET;
         busy_q <= 1'b1; drq_q <= 1'b0; seek_done_q <= 1'b0; corrected_flag_q <= 1'b0; err_q <= 1'b0;
         wf_seen_q <= 1'b0; pend_q <= 1'b0; long_q <= 1'b0; error_q <= ERR_NONE;
         left_q <= 9'h0; words_q <= 9'h0; wait_q <= 64'h0; cmd_q <= 8'h00;
      end
      else if (clk_en)
      begin
         wf_seen_q <= wf_s;
         if (rd_status)
            pend_q <= 1'b0;
         if (soft_rst)
         begin
            state_q <= S_RESET; busy_q <= 1'b1; drq_q <= 1'b0; wait_q <= 64'h0;
         end
         else
         case (state_q)
            S_RESET:
            begin
               state_q <= IS_SLAVE ? S_DONE : S_DIAG;
               error_q <= ERR_NONE;
            end
            S_DIAG:
            begin
               wait_q <= wait_q + 64'h1;
               if (!diag_s) state_q <= S_DONE;
               else if (wait_q >= 64'(DIAG_WAIT))
               begin
                  error_q <= ERR_SLAVE;
                  state_q <= S_DONE;
               end
            end
            S_IDLE:
               if (cmd_wr)
               begin
                  busy_q <= 1'b1;
                  cmd_q  <= host_wdata;
                  err_q <= 1'b0; corrected_flag_q <= 1'b0;
                  if (!can_run || cls == CMD_BAD || (cls == CMD_READ && host_wdata[CMD_LONG] && count_q != 8'h01))
                  begin
                     err_q <= 1'b1; error_q <= ERR_ABORT; state_q <= S_DONE;
                  end
                  else if (cls == CMD_RECAL || cls == CMD_SEEK || cls == CMD_READ)
                  begin
                     seek_done_q <= 1'b0;
                     long_q  <= host_wdata[CMD_LONG];
                     left_q  <= (count_q == 8'h00) ? 9'(SECTOR_WORDS) : {1'b0, count_q};
                     state_q <= (cls == CMD_READ) ? S_SECT_WAIT : S_RECAL;
                  end
                  else
                     state_q <= S_DONE;
               end
            S_RECAL:
               if (!can_run) begin err_q <= 1'b1; error_q <= ERR_ABORT; state_q <= S_DONE; end
               else if (seek_s)
               begin
                  seek_done_q <= 1'b1;
                  if (cmd_q[7:4] == 4'h1 && !tk0_s) begin err_q <= 1'b1; error_q <= ERR_TRACK0; end
                  state_q <= S_DONE;
               end
            S_SECT_WAIT:
               if (!can_run) begin err_q <= 1'b1; error_q <= ERR_ABORT; state_q <= S_DONE; end
               else if (unc_s) begin err_q <= 1'b1; error_q <= ERR_UNCORR; state_q <= S_DONE; end
               else if (srdy_s)
               begin
                  seek_done_q <= 1'b1;
                  pend_q  <= 1'b1;
                  drq_q   <= 1'b1;
                  busy_q  <= 1'b0;
                  if (sector_corrected_in) corrected_flag_q <= 1'b1;
                  words_q <= long_q ? 9'(SECTOR_WORDS + LONG_BYTES) : 9'(SECTOR_WORDS);
                  state_q <= S_SECT_XFER;
               end
            S_SECT_XFER:
               if (data_word_taken)
               begin
                  words_q <= words_q - 9'h1;
                  if (words_q == 9'h1)
                  begin
                     drq_q  <= 1'b0;
                     left_q <= left_q - 9'h1;
                     busy_q <= (left_q != 9'h1);
                     state_q <= (left_q == 9'h1) ? S_IDLE : S_SECT_WAIT;
                  end
               end
            S_DONE:
            begin
               busy_q  <= 1'b0;
               pend_q  <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Read mux and outputs
   // ----------------------------------------
   logic [7:0] din_view;
   assign din_view = {chg_s & floppy_present, 1'b1, ~head_q[3:0], ~head_q[HD_UNIT], head_q[HD_UNIT]};
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         host_rdata <= 8'h00; host_rdata_oe <= 1'b0;
         host_interrupt_line <= 1'b0; host_interrupt_oe <= 1'b0;
         diag_passed_line_out <= 1'b0; diag_passed_line_oe <= 1'b0;
         seek_req <= 1'b0; seek_to_zero <= 1'b0; ecc_correct_en <= 1'b0;
         unit_slave_sel <= 1'b0; head_select_bits <= 4'h0; write_gate_line_n <= 1'b1;
         drive_select_lines_n <= 2'h3; sectors_left <= 9'h0;
      end
      else if (clk_en)
      begin
         host_rdata_oe <= ~rd_n_s & (sel_pri | (sel_aux & host_addr_lines[2:1] == 2'h3 &&
                          !(host_addr_lines == ADDR_AUX_DIN && !floppy_present)));
         if (sel_aux)
            host_rdata <= (host_addr_lines == ADDR_AUX_DIN) ? din_view : status;
         else if (busy_q || host_addr_lines == ADDR_STATUS)
            host_rdata <= status;
         else if (host_addr_lines == ADDR_HEAD)
            host_rdata <= head_q;
         else if (host_addr_lines == ADDR_COUNT)
            host_rdata <= count_q;
         else if (host_addr_lines == ADDR_ERROR)
            host_rdata <= error_q;
         else
            host_rdata <= 8'h00;
         host_interrupt_line <= pend_q & ~rd_status;
         host_interrupt_oe   <= ~ctl_q[CTL_IDS];
         diag_passed_line_out <= 1'b0;
         diag_passed_line_oe  <= IS_SLAVE & ~soft_rst & (state_q != S_RESET);
         seek_req      <= (state_q == S_RECAL) || (state_q == S_SECT_WAIT);
         seek_to_zero  <= (state_q == S_RECAL) && cmd_q[7:4] == 4'h1;
         ecc_correct_en <= ~cmd_q[CMD_NORETRY] & ~long_q;
         unit_slave_sel   <= head_q[HD_UNIT];
         head_select_bits <= head_q[3:0];
         write_gate_line_n <= 1'b1;
         drive_select_lines_n <= {~head_q[HD_UNIT], head_q[HD_UNIT]};
         sectors_left <= left_q;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence cmd_taken_s;
      clk_en && cmd_wr && state_q == S_IDLE && !soft_rst;
   endsequence
   busy_on_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
      cmd_taken_s |=> busy_q) else $error("busy not set by command");
   refuse_notready_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_taken_s and !can_run) |=> err_q && state_q == S_DONE) else $error("command not refused");
   // A new interrupt raised in the same cycle as the read wins over the clear
   status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && rd_status && state_q != S_DONE && state_q != S_SECT_WAIT |=> !pend_q)
      else $error("status read left interrupt");
   irq_line_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !pend_q && !rd_status |=> !host_interrupt_line) else $error("interrupt without pending");
   ids_tristate_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && ctl_q[CTL_IDS] |=> !host_interrupt_oe) else $error("line driven while disabled");
   busy_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && busy_q && sel_pri |=> host_rdata == $past(status)) else $error("busy read not status");
   soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && soft_rst |=> busy_q && state_q == S_RESET) else $error("not held in reset");
   drq_sector_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state_q == S_SECT_WAIT && can_run && !unc_s && srdy_s && !soft_rst |=> drq_q && pend_q)
      else $error("sector without interrupt");
endmodule : disk_task_file_host_port

// ### test/host_adapter_model.sv
// Host adapter model that drives the task-file bus cycles
`timescale 1ns/10ps
module host_adapter_model (
   input  wire logic       clk,
   output logic            cs_p_n,
   output logic            cs_a_n,
   output logic [2:0]      addr,
   output logic            rd_n,
   output logic            wr_n,
   output logic [7:0]      wdata,
   input  wire logic [7:0] rdata
);
   // Idle bus at time zero
   initial
   begin
      cs_p_n = 1'b1;
      cs_a_n = 1'b1;
      addr = 3'h0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      wdata = 8'h00;
   end

   // One access; strobe held well past the port's sync delay
   task automatic acc(input bit aux, input logic [2:0] a, input bit w, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      cs_p_n <= aux;
      cs_a_n <= !aux;
      addr <= a;
      wdata <= d;
      repeat (2) @(posedge clk);
      rd_n <= w;
      wr_n <= !w;
      repeat (6) @(posedge clk);
      q = rdata;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      cs_p_n <= 1'b1;
      cs_a_n <= 1'b1;
      addr <= ~a; // Released bus shows no stale value
      wdata <= ~d;
   endtask : acc
endmodule : host_adapter_model

// ### test/disk_task_file_host_port_tb.sv
// Self-checking bench for the task-file host port
`timescale 1ns/10ps
module disk_task_file_host_port_tb;
   import task_file_pkg::*;
   logic clk, rst_n, cs_p_n, cs_a_n, rd_n, wr_n, int_line, int_oe, d_out, d_oe, diag;
   logic rdy, wf, idx, seek_done, sec_rdy, sec_corrected_flag, word, seek_req, seek_zero, ecc_en, unit;
   logic tk0, unc, wg_n;
   logic [1:0] dsel;
   logic [8:0] left;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   logic [3:0] heads;
   int err_total, check_count, cyc;

   assign diag = d_oe ? d_out : 1'b1; // Pulled-up open-drain line

   host_adapter_model host (.clk(clk), .cs_p_n(cs_p_n), .cs_a_n(cs_a_n), .addr(addr),
      .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata));

   disk_task_file_host_port #(.DIAG_WAIT(100), .IS_SLAVE(1'b0)) dut (.clk(clk), .rst_n(rst_n),
      .clk_en(1'b1), .primary_chip_select_n(cs_p_n), .aux_chip_select_n(cs_a_n),
      .host_addr_lines(addr), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_wdata(wdata),
      .host_rdata(rdata), .host_rdata_oe(), .host_interrupt_line(int_line),
      .host_interrupt_oe(int_oe), .diag_passed_line_in(diag), .diag_passed_line_out(d_out),
      .diag_passed_line_oe(d_oe), .drive_ready_in(rdy), .write_fault_in(wf), .index_in(idx),
      .seek_done_in(seek_done), .track_zero_in(tk0), .media_change_in(1'b0),
      .floppy_present(1'b0), .sector_ready_in(sec_rdy), .sector_corrected_in(sec_corrected_flag),
      .sector_uncorrectable_in(unc), .data_word_taken(word), .seek_req(seek_req),
      .seek_to_zero(seek_zero), .ecc_correct_en(ecc_en), .unit_slave_sel(unit),
      .head_select_bits(heads), .write_gate_line_n(wg_n), .drive_select_lines_n(dsel), .sectors_left(left));

   // Clock, 25 ns period
   always #12.5 clk = ~clk;

   // Cycle ceiling against a hang
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input bit x, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.acc(x, a, 1'b1, d, q);
   endtask : wr

   task automatic rd(input bit x, input logic [2:0] a, output logic [7:0] q);
      host.acc(x, a, 1'b0, 8'h00, q);
   endtask : rd

   // Poll the shadow status until busy drops
   task automatic wait_idle;
      logic [7:0] s;
      s = 8'hff;
      for (int i = 0; i < 300 && s[7] !== 1'b0; i++) rd(1, ADDR_AUX_CTL, s);
      if (s[7] !== 1'b0) chk(s, 8'h00);
   endtask : wait_idle

   // Power-up: no slave answer, interrupts disabled
   task automatic t_reset;
      logic [7:0] q;
      wait_idle();
      rd(0, ADDR_ERROR, q);
      chk(q, ERR_SLAVE);
      chk({7'h00, int_oe}, 8'h00);
      chk({7'h00, wg_n}, 8'h01);
   endtask : t_reset

   // Enable fires the pending interrupt; only primary status clears it
   task automatic t_irq;
      logic [7:0] a, q;
      wr(1, ADDR_AUX_CTL, 8'h00);
      chk({6'h00, int_oe, int_line}, 8'h03);
      rd(1, ADDR_AUX_CTL, a);
      chk({7'h00, int_line}, 8'h01);
      chk(a & 8'he2, 8'h42);
      rd(0, ADDR_STATUS, q);
      chk(q, a);
      chk({7'h00, int_line}, 8'h00);
   endtask : t_irq

   // Unit and head fields, with the inverted digital view
   task automatic t_head;
      logic [7:0] q;
      logic [7:0] v [2] = '{8'hb5, 8'ha0};
      foreach (v[i])
      begin
         wr(0, ADDR_HEAD, v[i]);
         chk({3'h0, unit, heads}, {3'h0, v[i][4:0]});
         rd(0, ADDR_HEAD, q);
         chk(q, v[i]);
         rd(1, ADDR_AUX_DIN, q);
         chk(q & 8'h3c, {2'h0, ~v[i][3:0], 2'h0});
         chk({6'h00, dsel}, {6'h00, ~v[i][4], v[i][4]});
      end
   endtask : t_head

   // Recalibrate held until the seek completes, with or without track zero found
   task automatic t_recal(input bit fail);
      logic [7:0] a, q;
      @(posedge clk)
      begin
         seek_done <= 1'b0;
         tk0 <= !fail;
      end
      wr(0, ADDR_STATUS, 8'h10);
      rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h80, 8'h80);
      rd(0, ADDR_HEAD, q);
      chk(q, a);
      chk({6'h00, seek_req, seek_zero}, 8'h03);
      @(posedge clk) seek_done <= 1'b1;
      wait_idle();
      rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h91, fail ? 8'h11 : 8'h10);
      chk({7'h00, int_line}, 8'h01);
      rd(0, ADDR_ERROR, q);
      if (fail) chk(q, ERR_TRACK0);
      rd(0, ADDR_STATUS, q);
   endtask : t_recal

   // Refusals: not ready, write fault, unknown opcode, long read of two; then an uncorrectable sector
   task automatic t_refuse(input int k);
      logic [7:0] a, q;
      @(posedge clk)
      begin
         rdy <= (k != 0);
         wf <= (k == 1);
         unc <= (k == 4);
      end
      if (k == 3) wr(0, ADDR_COUNT, 8'h02);
      repeat (4) @(posedge clk);
      rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h60, k == 0 ? 8'h00 : k == 1 ? 8'h60 : 8'h40);
      wr(0, ADDR_STATUS, k == 2 ? 8'h00 : k == 3 ? 8'h22 : k == 4 ? 8'h20 : 8'h10);
      wait_idle();
      rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h01, 8'h01);
      rd(0, ADDR_ERROR, q);
      chk(q, k == 4 ? ERR_UNCORR : ERR_ABORT);
      @(posedge clk)
      begin
         rdy <= 1'b1;
         wf <= 1'b0;
         unc <= 1'b0;
      end
      rd(0, ADDR_STATUS, q);
   endtask : t_refuse

   // One corrected sector read in full
   task automatic t_read;
      logic [7:0] a;
      a = 8'h00;
      @(posedge clk)
      begin
         sec_rdy <= 1'b1;
         sec_corrected_flag <= 1'b1;
      end
      wr(0, ADDR_COUNT, 8'h01);
      wr(0, ADDR_STATUS, 8'h20);
      for (int i = 0; i < 100 && a[3] !== 1'b1; i++) rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h08, 8'h08);
      chk({6'h00, int_line, ecc_en}, 8'h03);
      chk(left[7:0], 8'h01);
      @(posedge clk) sec_rdy <= 1'b0;
      repeat (SECTOR_WORDS)
      begin
         @(posedge clk) word <= 1'b1;
         @(posedge clk) word <= 1'b0;
      end
      wait_idle();
      rd(1, ADDR_AUX_CTL, a);
      chk(a & 8'h0d, 8'h04);
      rd(0, ADDR_STATUS, a);
   endtask : t_read

   // Soft reset held past its minimum, then released
   task automatic t_soft;
      logic [7:0] q;
      wr(1, ADDR_AUX_CTL, 8'h04);
      repeat (RST_MIN_CYC) @(posedge clk);
      wr(1, ADDR_AUX_CTL, 8'h00);
      wait_idle();
      rd(0, ADDR_ERROR, q);
      chk(q, ERR_SLAVE);
   endtask : t_soft

   task automatic final_report;
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      {clk, rst_n, seek_done, sec_rdy, sec_corrected_flag, word, wf, unc} = '0;
      {rdy, idx, tk0} = 3'b111;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_irq();
      t_head();
      t_recal(1'b0);
      t_recal(1'b1);
      for (int k = 0; k < 5; k++) t_refuse(k);
      t_read();
      t_soft();
      final_report();
   end
endmodule : disk_task_file_host_port_tb
